//--- rtl/cic_params.svh
/*
 Constants of the core interrupt controller: register offsets, bit positions,
 reset values and phase timing. Assumes inclusion by bare name.
*/
`ifndef CIC_PARAMS_SVH
`define CIC_PARAMS_SVH
`define CIC_ADDR_W        4
`define CIC_OFS_CONTROL   4'h0
`define CIC_OFS_OPTION    4'h1
`define CIC_OFS_PEN1      4'h2
`define CIC_OFS_PEN2      4'h3
`define CIC_OFS_SH_W      4'h4
`define CIC_OFS_SH_STATUS 4'h5
`define CIC_OFS_SH_BSR    4'h6
`define CIC_OFS_SH_FSR0L  4'h7
`define CIC_OFS_SH_FSR0H  4'h8
`define CIC_OFS_SH_FSR1L  4'h9
`define CIC_OFS_SH_FSR1H  4'hA
`define CIC_OFS_SH_PC_HIGH_LATCH 4'hB
`define CIC_OFS_STATE     4'hC
`define CIC_BIT_GIE       7
`define CIC_BIT_PERIPHERAL_IRQ_ENABLE      6
`define CIC_BIT_T0IE      5
`define CIC_BIT_EXTIE     4
`define CIC_BIT_PCIE      3
`define CIC_BIT_T0IF      2
`define CIC_BIT_EXTIF     1
`define CIC_BIT_PCIF      0
`define CIC_BIT_EDGE      0
`define CIC_CTRL_RESET    8'h00
`define CIC_CTRL_WMASK    8'hFE
`define CIC_STATUS_KEEP   8'h18
`define CIC_VECTOR        15'h0004
`define CIC_Q_PHASES      2'h3
`endif

//--- rtl/cic_pkg.sv
/*
 Types of the core interrupt controller. Assumes cic_params.svh alongside.
*/
package cic_pkg;
  typedef enum logic [1:0]
  {
    CIC_RUN   = 2'h0,
    CIC_ENTRY = 2'h1,
    CIC_SLEEP = 2'h2,
    CIC_WAKE  = 2'h3
  } cic_state_t;
  typedef struct packed
  {
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] bank_select_reg;
    logic [7:0] fsr0l;
    logic [7:0] fsr0h;
    logic [7:0] fsr1l;
    logic [7:0] fsr1h;
    logic [7:0] pc_high_latch;
  } cic_ctx_t;
endpackage : cic_pkg

//--- rtl/cic_shadow_if.sv
/*
 Interface between the controller and its shadow bank. Assumes one clock.
*/
`timescale 1ns/10ps
interface cic_shadow_if;
  import cic_pkg::*;
  logic       save;
  logic       sw_we;
  logic [2:0] sw_idx;
  logic [7:0] sw_data;
  cic_ctx_t   live;
  cic_ctx_t   saved;
  modport ctrl (output save, output sw_we, output sw_idx, output sw_data,
                output live, input saved);
  modport bank (input save, input sw_we, input sw_idx, input sw_data,
                input live, output saved);
endinterface : cic_shadow_if

//--- rtl/cic_shadow.sv
/*
 Shadow context bank: captured on interrupt entry, writable by software.
 Assumes the save pulse and software writes never coincide for one byte.
*/
`timescale 1ns/10ps
`include "cic_params.svh"
module cic_shadow
  import cic_pkg::*;
(
  input  wire logic   clock_i,
  input  wire logic   rst_n_i,
  cic_shadow_if.bank  sh
);
  typedef struct packed
  {
    logic [7:0][7:0] bytes_reg;
  } cic_sh_state_t;
  cic_sh_state_t st_reg;
  cic_sh_state_t st_next;
  logic [7:0][7:0] live_b;
  assign live_b = sh.live;

  always_comb
  begin
    st_next = st_reg;
    for (int i = 0; i < 8; i++)
    begin
      if (sh.save)
        st_next.bytes_reg[i] = live_b[i];
      else if (sh.sw_we && sh.sw_idx == 3'(7 - i))
        st_next.bytes_reg[i] = sh.sw_data;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sh.saved = st_reg.bytes_reg;
endmodule : cic_shadow

//--- rtl/cic_core_irq.sv
/*
 Core interrupt controller: control register, flags, enables, entry and
 return sequencing, sleep wake and shadow context. Assumes a sequencer that
 issues q1_i once per instruction cycle and acts on the vector request.
*/
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "cic_params.svh"
module cic_core_irq
  import cic_pkg::*;
#(
  parameter int PERIPH_W = 8
)
(
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  input  wire logic [`CIC_ADDR_W-1:0]  addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [7:0]              rdata_o,
  input  wire logic                    q1_i,
  input  wire logic                    q4_i,
  input  wire logic                    ext_pin_i,
  input  wire logic                    timer0_ovf_i,
  input  wire logic [7:0]              port_change_flags_i,
  input  wire logic [PERIPH_W-1:0]     periph_flags_1_i,
  input  wire logic [PERIPH_W-1:0]     periph_flags_2_i,
  input  wire logic                    sleep_i,
  input  wire logic                    return_from_irq_i,
  input  wire logic [14:0]             pc_i,
  input  cic_ctx_t                     live_ctx_i,
  output logic                         irq_request_o,
  output logic                         vector_o,
  output logic      [14:0]             vector_pc_o,
  output logic                         flush_o,
  output logic                         push_pc_o,
  output logic      [14:0]             push_data_o,
  output logic                         pop_pc_o,
  output logic                         restore_o,
  output cic_ctx_t                     restore_ctx_o,
  output logic                         wake_o
);
  typedef struct packed
  {
    logic [7:0]          ctrl;
    logic                edge_sel;
    logic [PERIPH_W-1:0] pen1;
    logic [PERIPH_W-1:0] pen2;
    logic                pin_d;
    logic                ext_hold;
    logic                pending;
    cic_state_t          state;
    logic                vector;
    logic                push;
    logic [14:0]         push_data;
    logic                pop;
    logic                restore;
    logic                wake;
    logic [7:0]          rdata;
  } cic_core_state_t;

  cic_core_state_t st_reg;
  cic_core_state_t st_next;
  cic_shadow_if    sh ();
  logic            global_irq_enable;
  logic            core_req;
  logic            periph_req;
  logic            req;
  logic            pin_edge;
  logic            pc_flag;
  logic [7:0]      sh_rd;

  cic_shadow u_shadow
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .sh      (sh)
  );

  assign global_irq_enable     = st_reg.ctrl[`CIC_BIT_GIE];
  assign pc_flag = |port_change_flags_i;
  assign pin_edge = st_reg.edge_sel ? (ext_pin_i & ~st_reg.pin_d)
                                    : (~ext_pin_i & st_reg.pin_d);
  assign core_req =
      (st_reg.ctrl[`CIC_BIT_T0IE]  & st_reg.ctrl[`CIC_BIT_T0IF])
    | (st_reg.ctrl[`CIC_BIT_EXTIE] & st_reg.ctrl[`CIC_BIT_EXTIF])
    | (st_reg.ctrl[`CIC_BIT_PCIE]  & pc_flag);
  assign periph_req = st_reg.ctrl[`CIC_BIT_PERIPHERAL_IRQ_ENABLE]
    & (|(periph_flags_1_i & st_reg.pen1) | |(periph_flags_2_i & st_reg.pen2));
  assign req = core_req | periph_req;

  // Shadow writes land by index; status keeps its live expiry/powerdown bits
  assign sh.save    = st_reg.state == CIC_RUN && st_reg.pending && q1_i;
  assign sh.sw_we   = wr_i && addr_i >= `CIC_OFS_SH_W && addr_i <= `CIC_OFS_SH_PC_HIGH_LATCH;
  assign sh.sw_idx  = 3'(addr_i - `CIC_OFS_SH_W);
  assign sh.sw_data = wdata_i;
  assign sh.live    = live_ctx_i;

  always_comb
  begin
    sh_rd = 8'h00;
    case (addr_i)
      `CIC_OFS_SH_W:      sh_rd = sh.saved.w;
      `CIC_OFS_SH_STATUS: sh_rd = sh.saved.status;
      `CIC_OFS_SH_BSR:    sh_rd = sh.saved.bank_select_reg;
      `CIC_OFS_SH_FSR0L:  sh_rd = sh.saved.fsr0l;
      `CIC_OFS_SH_FSR0H:  sh_rd = sh.saved.fsr0h;
      `CIC_OFS_SH_FSR1L:  sh_rd = sh.saved.fsr1l;
      `CIC_OFS_SH_FSR1H:  sh_rd = sh.saved.fsr1h;
      `CIC_OFS_SH_PC_HIGH_LATCH: sh_rd = sh.saved.pc_high_latch;
      default:            sh_rd = 8'h00;
    endcase
  end

  always_comb
  begin
    st_next         = st_reg;
    st_next.vector  = 1'b0;
    st_next.push    = 1'b0;
    st_next.pop     = 1'b0;
    st_next.restore = 1'b0;
    st_next.wake    = 1'b0;
    st_next.pin_d   = ext_pin_i;
    // Software writes first so a same-cycle event below wins over a clear
    if (wr_i)
    begin
      case (addr_i)
        `CIC_OFS_CONTROL:
          st_next.ctrl = (wdata_i & `CIC_CTRL_WMASK)
                       | (st_reg.ctrl & ~`CIC_CTRL_WMASK);
        `CIC_OFS_OPTION: st_next.edge_sel = wdata_i[`CIC_BIT_EDGE];
        `CIC_OFS_PEN1:   st_next.pen1 = wdata_i[PERIPH_W-1:0];
        `CIC_OFS_PEN2:   st_next.pen2 = wdata_i[PERIPH_W-1:0];
        default:         st_next.ctrl = st_next.ctrl;
      endcase
    end
    if (timer0_ovf_i)
      st_next.ctrl[`CIC_BIT_T0IF] = 1'b1;
    // Edge held until the next Q4/Q1 window so a mid-cycle edge is not lost
    st_next.ext_hold = (st_reg.ext_hold | pin_edge) & ~(q4_i | q1_i);
    if ((pin_edge || st_reg.ext_hold) && (q4_i || q1_i))
      st_next.ctrl[`CIC_BIT_EXTIF] = 1'b1;
    st_next.ctrl[`CIC_BIT_PCIF] = pc_flag;
    // Request sampled once per instruction cycle so latency is cycle-aligned
    if (q1_i)
      st_next.pending = req && global_irq_enable;
    st_next.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `CIC_OFS_CONTROL: st_next.rdata = {st_reg.ctrl[7:1], pc_flag};
        `CIC_OFS_OPTION:  st_next.rdata = {7'h00, st_reg.edge_sel};
        `CIC_OFS_PEN1:    st_next.rdata = 8'(st_reg.pen1);
        `CIC_OFS_PEN2:    st_next.rdata = 8'(st_reg.pen2);
        `CIC_OFS_STATE:   st_next.rdata = {5'h00, st_reg.pending, st_reg.state};
        default:          st_next.rdata = sh_rd;
      endcase
    end
    case (st_reg.state)
      CIC_RUN:
      begin
        if (return_from_irq_i)
        begin
          st_next.pop     = 1'b1;
          st_next.restore = 1'b1;
          st_next.ctrl[`CIC_BIT_GIE] = 1'b1;
        end
        else if (st_reg.pending && q1_i)
        begin
          st_next.vector    = 1'b1;
          st_next.push      = 1'b1;
          st_next.push_data = pc_i;
          st_next.pending   = 1'b0;
          st_next.ctrl[`CIC_BIT_GIE] = 1'b0;
          st_next.state     = CIC_ENTRY;
        end
        else if (sleep_i)
          st_next.state = CIC_SLEEP;
      end
      CIC_ENTRY:
        st_next.state = CIC_RUN;
      CIC_SLEEP:
      begin
        if (req)
        begin
          st_next.wake  = 1'b1;
          st_next.state = CIC_WAKE;
        end
      end
      CIC_WAKE:
      begin
        // One instruction after sleep runs before any vectoring
        if (q1_i)
          st_next.state = CIC_RUN;
      end
      default:
        st_next.state = CIC_RUN;
    endcase
    if (st_reg.state != CIC_RUN)
      st_next.pending = 1'b0;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg       <= '0;
      st_reg.ctrl  <= `CIC_CTRL_RESET;
      st_reg.state <= CIC_RUN;
    end
    else
      st_reg <= st_next;
  end

  always_comb
  begin
    restore_ctx_o        = sh.saved;
    restore_ctx_o.status = (sh.saved.status & ~`CIC_STATUS_KEEP)
                         | (live_ctx_i.status & `CIC_STATUS_KEEP);
  end

  assign rdata_o       = st_reg.rdata;
  assign irq_request_o = req && global_irq_enable;
  assign vector_o      = st_reg.vector;
  assign vector_pc_o   = `CIC_VECTOR;
  assign flush_o       = st_reg.vector;
  assign push_pc_o     = st_reg.push;
  assign push_data_o   = st_reg.push_data;
  assign pop_pc_o      = st_reg.pop;
  assign restore_o     = st_reg.restore;
  assign wake_o        = st_reg.wake;

  chk_reset_disabled : assert property (@(posedge clock_i)
    $rose(rst_n_i) |-> !irq_request_o)
    else $error("interrupt active right after reset");
  chk_gated_request : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    irq_request_o |-> global_irq_enable && req)
    else $error("request without enables");
  chk_t0_flag_set : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    timer0_ovf_i |=> st_reg.ctrl[`CIC_BIT_T0IF])
    else $error("timer0 flag missed");
  sequence s_entry;
    vector_o && flush_o && push_pc_o;
  endsequence
  chk_entry_seq : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    vector_o |-> s_entry ##0 !global_irq_enable ##0 vector_pc_o == 15'h0004)
    else $error("entry sequence wrong");
  chk_no_vec_gie0 : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !global_irq_enable && !$past(global_irq_enable) |-> !vector_o)
    else $error("vectoring while disabled");
  chk_return_gie : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    restore_o |-> pop_pc_o && global_irq_enable)
    else $error("return did not set enable");
  chk_pinchange_ro : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ##1 st_reg.ctrl[`CIC_BIT_PCIF] == $past(pc_flag))
    else $error("pin-change flag mismatch");
  chk_wake_first : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wake_o |-> !vector_o ##1 !vector_o)
    else $error("vector before post-sleep instruction");
  chk_ext_edge : assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pin_edge && q1_i |=> st_reg.ctrl[`CIC_BIT_EXTIF])
    else $error("edge flag missed");
endmodule : cic_core_irq

//--- test/cic_seq_model.sv
/*
 Sequencer partner: four Q phases per instruction cycle, a PC and a
 one-level return stack. Assumes the controller pulses vector and pop.
*/
`timescale 1ns/10ps
module cic_seq_model
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        vector_i,
  input  wire logic [14:0] vector_pc_i,
  input  wire logic [14:0] push_data_i,
  input  wire logic        pop_i,
  output logic             q1_o,
  output logic             q4_o,
  output logic      [14:0] pc_o
);
  logic [1:0]  phase_reg;
  logic [14:0] stack_reg;
  assign q1_o = (phase_reg == 2'h0);
  assign q4_o = (phase_reg == 2'h3);
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase_reg <= 2'h0;
      pc_o      <= 15'h0000;
      stack_reg <= 15'h0000;
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1;
      // Jump and return win over the normal step
      if (vector_i)
      begin
        pc_o      <= vector_pc_i;
        stack_reg <= push_data_i;
      end
      else if (pop_i)
        pc_o <= stack_reg;
      else if (q1_o)
        pc_o <= pc_o + 15'h0001;
    end
  end
endmodule : cic_seq_model

//--- test/tb_core_interrupt_controller.sv
/*
 Testbench of the core interrupt controller: register tasks, flag,
 vectoring, return, peripheral gating and sleep scenarios.
 Assumes cic_params.svh and cic_pkg compiled alongside.
*/
`timescale 1ns/10ps
`include "cic_params.svh"
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin miscompares++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module tb_core_interrupt_controller;
  import cic_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        ext = 1'b0;
  logic        t0 = 1'b0;
  logic [7:0]  pcf = 8'h00;
  logic [7:0]  pf1 = 8'h00;
  logic        slp = 1'b0;
  logic        ret = 1'b0;
  cic_ctx_t    live = '0;
  logic [7:0]  rdata;
  logic [7:0]  v;
  logic        q1, q4, irq, vec, flush, push, pop, rest, wake;
  logic [14:0] vpc, pdata, pc;
  cic_ctx_t    rctx;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n;
  logic        got;
  always #2.5 clk = ~clk;
  cic_core_irq dut (.clock_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .q1_i(q1), .q4_i(q4), .ext_pin_i(ext),
    .timer0_ovf_i(t0), .port_change_flags_i(pcf), .periph_flags_1_i(pf1),
    .periph_flags_2_i(8'h00), .sleep_i(slp), .return_from_irq_i(ret), .pc_i(pc),
    .live_ctx_i(live), .irq_request_o(irq), .vector_o(vec), .vector_pc_o(vpc),
    .flush_o(flush), .push_pc_o(push), .push_data_o(pdata), .pop_pc_o(pop),
    .restore_o(rest), .restore_ctx_o(rctx), .wake_o(wake));
  cic_seq_model seq (.clock_i(clk), .rst_n_i(rst_n), .vector_i(vec), .vector_pc_i(vpc),
    .push_data_i(pdata), .pop_i(pop), .q1_o(q1), .q4_o(q4), .pc_o(pc));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd
  // One-cycle event on a strobe input: 0 timer, 1 sleep, 2 return
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) t0 <= 1'b1; else if (k == 1) slp <= 1'b1; else ret <= 1'b1;
    @(posedge clk);
    t0  <= 1'b0;
    slp <= 1'b0;
    ret <= 1'b0;
  endtask : pulse
  // Bounded wait for a one-cycle output pulse: 0 vector, 1 pop, 2 wake
  task automatic wait_evt(input int k, input int lim, output logic hit);
    n = 0;
    hit = 1'b0;
    while (hit !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
      hit = (k == 0) ? vec : (k == 1) ? pop : wake;
    end
  endtask : wait_evt
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h00)
    wr(`CIC_OFS_CONTROL, 8'h78);
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h78)
    wr(`CIC_OFS_CONTROL, 8'h00);
    pulse(0);
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h04)
    wait_evt(0, 40, got); `CHK(got, 1'b0)
    wr(`CIC_OFS_OPTION, 8'h01);
    ext <= 1'b1;
    repeat (12) @(posedge clk);
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h06)
    wr(`CIC_OFS_CONTROL, 8'h00);
    wr(`CIC_OFS_OPTION, 8'h00);
    ext <= 1'b0;
    repeat (12) @(posedge clk);
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h02)
    pcf <= 8'h10;
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h03)
    wr(`CIC_OFS_CONTROL, 8'h00);
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h01)
    pcf <= 8'h00;
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h00)
    // Entry, shadow edit and return
    live <= 64'h1122334455667788;
    wr(`CIC_OFS_CONTROL, 8'hA0);
    pulse(0);
    wait_evt(0, 20, got); `CHK(got, 1'b1)
    `CHK(vpc, 15'h0004)
    `CHK({flush, push}, 2'b11)
    rd(`CIC_OFS_CONTROL, v); `CHK(v, 8'h24)
    rd(`CIC_OFS_SH_BSR, v); `CHK(v, 8'h33)
    wr(`CIC_OFS_SH_W, 8'h5A);
    live <= 64'hFFFFFFFFFFFFFFFF;
    pulse(2);
    wait_evt(1, 4, got); `CHK(got, 1'b1)
    `CHK(rest, 1'b1)
    `CHK(rctx, 64'h5A3A334455667788)
    // Flag left set by the handler: taken again
    wait_evt(0, 20, got); `CHK(got, 1'b1)
    wr(`CIC_OFS_CONTROL, 8'h00);
    // Peripheral source needs its group enable
    wr(`CIC_OFS_PEN1, 8'h01);
    pf1 <= 8'h01;
    wr(`CIC_OFS_CONTROL, 8'h80);
    @(negedge clk); `CHK(irq, 1'b0)
    wr(`CIC_OFS_CONTROL, 8'hC0);
    @(negedge clk); `CHK(irq, 1'b1)
    wait_evt(0, 20, got); `CHK(got, 1'b1)
    pf1 <= 8'h00;
    // Wake without global enable continues, with it vectors later
    wr(`CIC_OFS_CONTROL, 8'h20);
    pulse(1);
    pulse(0);
    wait_evt(2, 40, got); `CHK(got, 1'b1)
    wait_evt(0, 24, got); `CHK(got, 1'b0)
    wr(`CIC_OFS_CONTROL, 8'hA0);
    pulse(1);
    pulse(0);
    wait_evt(2, 40, got); `CHK(got, 1'b1)
    wait_evt(0, 24, got); `CHK(got, 1'b1)
    `CHK(n > 1, 1'b1)
    report_and_stop();
  end
endmodule : tb_core_interrupt_controller
